/* tfc_features.sv */
// Operation
// - 16-bit feature word lives at EPC bank bit address 200h.
// - TID bit 14h reads one, flagging the feature word.
// - permanent bits: max backscatter at 209h, alarm flag at 20Fh.
// - writing one toggles a permanent bit; zero leaves it.
// - a permanent bit reads one while its feature is active.
// - only single WRITE changes them; locked bank needs SECURED.
// - permalocked EPC bank blocks all permanent bit changes.
// - action fires only on pointer 202h/204h, length one, mask 1b.
// - one select triggers at most one action.
// - action select with truncate set is ignored.
// - action select leaves protocol state and flags untouched.
// - actions trigger in any lock state.
// - a triggered action stays active until chip reset.
// - backscatter defaults to maximum; clearing bit reduces it.
// - 96-bit EPC shipped, low part holds 48-bit serial number.
// - after parallel action, next QUERY opens with handle AAAAh.
// - in parallel open state every tag executes shared-handle WRITE.
// - power-check action matches only with enough write power.
`timescale 1ns/1ps
`default_nettype none
`include "tfc_cfg.svh"
module tfc_features
    import tfc_pkg::*;
(
    // clock and reset
    input  wire logic        MCLK,
    input  wire logic        RST,
    // non-volatile image, valid on NV_LOAD
    input  wire logic        NV_LOAD,
    input  wire logic [15:0] NV_WORD,
    input  wire logic [47:0] TAG_SERIAL_NUMBER,
    // bank state from the protocol engine
    input  wire logic [1:0]  EPC_LOCK,
    input  wire logic        SECURED,
    // memory write request
    input  wire logic        WR_REQ,
    input  wire logic        WR_BLOCK,
    input  wire logic [15:0] WR_ADDR,
    input  wire logic [15:0] WR_DATA,
    // memory read of the feature word
    input  wire logic        RD_REQ,
    input  wire logic [15:0] RD_ADDR,
    // select command
    input  wire logic        SEL_REQ,
    input  wire logic [15:0] SEL_PTR,
    input  wire logic [7:0]  SEL_LEN,
    input  wire logic        SEL_MASK,
    input  wire logic        SEL_TRUNC,
    input  wire logic        PWR_OK,
    // query and parallel encoding
    input  wire logic        QUERY_REQ,
    // results
    output var  logic        WR_DONE,
    output var  logic        WR_REJECT,
    output var  logic        RD_VALID,
    output var  logic [15:0] RD_DATA,
    output var  logic        TID_CFG_IND,
    output var  logic        SEL_ACT,
    output var  logic        SEL_MATCH,
    output var  logic        MAX_BACKSCATTER,
    output var  logic        ARTICLE_ALARM_FLAG,
    output var  logic        PAR_ACTIVE,
    output var  logic        PWR_CHECK_ACTIVE,
    output var  logic        PAR_OPEN,
    output var  logic [15:0] PAR_HANDLE,
    output var  logic        PAR_WRITE_ALL,
    output var  logic [95:0] EPC_INIT,
    output var  logic        NV_STORE,
    output var  logic [15:0] NV_WORD_OUT
);
    ////////////////////////////////////////////////////////////////////////
    logic      bs_q;
    logic      aaf_q;
    logic      par_q;
    logic      pwr_q;
    logic      wr_hit;
    logic      wr_ok;
    logic      tog_bs;
    logic      tog_aaf;
    logic      act_ok;
    logic      act_par;
    logic      act_pwr;
    tfc_par_e  par_st;
    tfc_word_t cfg_word;

    // single WRITE only; permalock wins over SECURED
    assign wr_hit = WR_REQ && (WR_ADDR == `TFC_CFG_WORD_ADDR);
    assign wr_ok  = wr_hit && !WR_BLOCK
                 && (EPC_LOCK != TFC_PERMALOCK)
                 && ((EPC_LOCK == TFC_UNLOCKED) || SECURED);
    assign tog_bs  = wr_ok && WR_DATA[`TFC_BIT_BS];
    assign tog_aaf = wr_ok && WR_DATA[`TFC_BIT_AAF];

    tfc_toggle_bit #(.RST_VAL(`TFC_RST_BS)) u_bs
    (
        .MCLK    (MCLK),
        .RST     (RST),
        .nv_load (NV_LOAD),
        .nv_val  (NV_WORD[`TFC_BIT_BS]),
        .toggle  (tog_bs),
        .q       (bs_q)
    );
    tfc_toggle_bit #(.RST_VAL(`TFC_RST_AAF)) u_aaf
    (
        .MCLK    (MCLK),
        .RST     (RST),
        .nv_load (NV_LOAD),
        .nv_val  (NV_WORD[`TFC_BIT_AAF]),
        .toggle  (tog_aaf),
        .q       (aaf_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // exact pointer, length and mask; pointer picks one action only
    assign act_ok  = SEL_REQ && !SEL_TRUNC
                  && (SEL_LEN == `TFC_SEL_LEN)
                  && (SEL_MASK == `TFC_SEL_MASK);
    assign act_par = act_ok && (SEL_PTR == `TFC_ACT_PAR_ADDR);
    assign act_pwr = act_ok && (SEL_PTR == `TFC_ACT_PWR_ADDR);

    // lock state not consulted; only chip reset clears
    always_ff @(posedge MCLK)
    begin
        if (RST)
            par_q <= 1'b0;
        else if (act_par)
            par_q <= 1'b1;
    end
    always_ff @(posedge MCLK)
    begin
        if (RST)
            pwr_q <= 1'b0;
        else if (act_pwr && PWR_OK)
            pwr_q <= 1'b1;
    end

    // select result; no protocol state touched here
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            SEL_ACT   <= 1'b0;
            SEL_MATCH <= 1'b0;
        end
        else
        begin
            SEL_ACT   <= act_par || act_pwr;
            SEL_MATCH <= act_par || (act_pwr && PWR_OK);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // parallel encoding: query jumps straight to open with fixed handle
    always_ff @(posedge MCLK)
    begin
        if (RST)
            par_st <= TFC_IDLE;
        else
        begin
            case (par_st)
                TFC_IDLE: if (act_par) par_st <= TFC_ARM;
                TFC_ARM:  if (QUERY_REQ) par_st <= TFC_OPEN;
                TFC_OPEN: par_st <= TFC_OPEN;
                default:  par_st <= TFC_IDLE;
            endcase
        end
    end
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            PAR_OPEN      <= 1'b0;
            PAR_HANDLE    <= 16'h0000;
            PAR_WRITE_ALL <= 1'b0;
        end
        else
        begin
            PAR_OPEN      <= (par_st == TFC_OPEN);
            PAR_HANDLE    <= (par_st == TFC_OPEN) ? `TFC_PAR_HANDLE
                                                  : 16'h0000;
            // every tag takes the shared-handle write, no arbitration
            PAR_WRITE_ALL <= (par_st == TFC_OPEN) && WR_REQ
                          && !WR_BLOCK;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        cfg_word = 16'h0000;
        cfg_word[`TFC_BIT_PAR] = par_q;
        cfg_word[`TFC_BIT_PWR] = pwr_q;
        cfg_word[`TFC_BIT_BS]  = bs_q;
        cfg_word[`TFC_BIT_AAF] = aaf_q;
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            RD_VALID <= 1'b0;
            RD_DATA  <= 16'h0000;
        end
        else
        begin
            RD_VALID <= RD_REQ && (RD_ADDR == `TFC_CFG_WORD_ADDR);
            RD_DATA  <= (RD_REQ && (RD_ADDR == `TFC_CFG_WORD_ADDR))
                      ? cfg_word : 16'h0000;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            WR_DONE   <= 1'b0;
            WR_REJECT <= 1'b0;
        end
        else
        begin
            WR_DONE   <= wr_ok;
            WR_REJECT <= wr_hit && !wr_ok;
        end
    end

    // store request so the toggled value persists in the NV array
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            NV_STORE    <= 1'b0;
            NV_WORD_OUT <= 16'h0000;
        end
        else
        begin
            NV_STORE    <= (tog_bs || tog_aaf) && !NV_LOAD;
            // carry the toggled bits, not the word before the write
            NV_WORD_OUT               <= cfg_word;
            NV_WORD_OUT[`TFC_BIT_BS]  <= bs_q ^ tog_bs;
            NV_WORD_OUT[`TFC_BIT_AAF] <= aaf_q ^ tog_aaf;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            TID_CFG_IND        <= 1'b0;
            MAX_BACKSCATTER    <= `TFC_RST_BS;
            ARTICLE_ALARM_FLAG <= `TFC_RST_AAF;
            PAR_ACTIVE         <= 1'b0;
            PWR_CHECK_ACTIVE   <= 1'b0;
            EPC_INIT           <= 96'h0;
        end
        else
        begin
            TID_CFG_IND        <= 1'b1;
            MAX_BACKSCATTER    <= bs_q;
            ARTICLE_ALARM_FLAG <= aaf_q;
            PAR_ACTIVE         <= par_q;
            PWR_CHECK_ACTIVE   <= pwr_q;
            EPC_INIT           <= {48'h0, TAG_SERIAL_NUMBER};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    AST_PERMA_NO_CHANGE: assert property (@(posedge MCLK)
        disable iff (RST)
        (WR_REQ && EPC_LOCK == TFC_PERMALOCK && !NV_LOAD)
        |=> $stable(bs_q) && $stable(aaf_q))
        else $error("permanent bit changed under permalock");
    AST_BLOCK_NO_CHANGE: assert property (@(posedge MCLK)
        disable iff (RST)
        (WR_REQ && WR_BLOCK && !NV_LOAD)
        |=> $stable(bs_q) && $stable(aaf_q))
        else $error("block write changed a permanent bit");
    AST_TOGGLE: assert property (@(posedge MCLK)
        disable iff (RST)
        (tog_bs && !NV_LOAD) |=> bs_q != $past(bs_q))
        else $error("write of one did not toggle");
    AST_TOGGLE_AAF: assert property (@(posedge MCLK)
        disable iff (RST)
        (tog_aaf && !NV_LOAD) |=> aaf_q != $past(aaf_q))
        else $error("write of one did not toggle alarm flag");
    AST_TRUNC_IGNORED: assert property (@(posedge MCLK)
        disable iff (RST)
        (SEL_REQ && SEL_TRUNC) |=> !SEL_ACT)
        else $error("truncated select acted");
    AST_ACTION_STICKY: assert property (@(posedge MCLK)
        disable iff (RST)
        PAR_ACTIVE |=> PAR_ACTIVE)
        else $error("action cleared without reset");
    AST_PWR_STICKY: assert property (@(posedge MCLK)
        disable iff (RST)
        PWR_CHECK_ACTIVE |=> PWR_CHECK_ACTIVE)
        else $error("power check cleared without reset");
    AST_ONE_ACTION: assert property (@(posedge MCLK)
        disable iff (RST)
        !(act_par && act_pwr))
        else $error("two actions in one select");
    AST_PAR_HANDLE: assert property (@(posedge MCLK)
        disable iff (RST)
        (par_st == TFC_ARM && QUERY_REQ) |=> ##1
        (PAR_OPEN && PAR_HANDLE == `TFC_PAR_HANDLE))
        else $error("parallel open handle wrong");
    AST_RSV_ZERO: assert property (@(posedge MCLK)
        disable iff (RST)
        RD_VALID |-> (RD_DATA & 16'h7DEB) == 16'h0000)
        else $error("reserved bit read nonzero");
    AST_PWR_MATCH: assert property (@(posedge MCLK)
        disable iff (RST)
        (act_pwr && !PWR_OK) |=> !SEL_MATCH)
        else $error("power check matched without power");
    AST_NV_IMAGE: assert property (@(posedge MCLK)
        disable iff (RST)
        ((tog_bs || tog_aaf) && !NV_LOAD) |=> NV_STORE
        && NV_WORD_OUT[`TFC_BIT_BS] == bs_q
        && NV_WORD_OUT[`TFC_BIT_AAF] == aaf_q)
        else $error("stored image misses the toggled bits");
endmodule : tfc_features
`default_nettype wire

/* tfc_cfg.svh */
`ifndef TFC_CFG_SVH
`define TFC_CFG_SVH
// word location in the EPC bank (bit address)
`define TFC_CFG_WORD_ADDR    16'h0200
`define TFC_ACT_PAR_ADDR     16'h0202
`define TFC_ACT_PWR_ADDR     16'h0204
`define TFC_PERM_BS_ADDR     16'h0209
`define TFC_PERM_AAF_ADDR    16'h020F
`define TFC_TID_IND_ADDR     8'h14
// field positions inside the word (bit 0 = 200h)
`define TFC_BIT_PAR          2
`define TFC_BIT_PWR          4
`define TFC_BIT_BS           9
`define TFC_BIT_AAF          15
// reset values, fixed handle, select and EPC length constants
`define TFC_RST_BS           1'b1
`define TFC_RST_AAF          1'b0
`define TFC_PAR_HANDLE       16'hAAAA
`define TFC_SEL_LEN          8'h01
`define TFC_SEL_MASK         1'b1
`define TFC_EPC_LEN_96       5'h06
// guard the interrogator keeps after an action select
`define TFC_GUARD_US         80
`define TFC_CLK_MHZ          20
`define TFC_GUARD_CYC        (`TFC_GUARD_US * `TFC_CLK_MHZ)
`endif

/* tfc_pkg.sv */
package tfc_pkg;
    typedef enum logic [1:0] {
        TFC_UNLOCKED  = 2'h0,
        TFC_LOCKED    = 2'h1,
        TFC_PERMALOCK = 2'h3
    } tfc_lock_e;
    typedef enum logic [1:0] {
        TFC_IDLE = 2'h0,
        TFC_ARM  = 2'h1,
        TFC_OPEN = 2'h3
    } tfc_par_e;
    typedef logic [15:0] tfc_word_t;
endpackage : tfc_pkg

/* tfc_toggle_bit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tfc_cfg.svh"
module tfc_toggle_bit
#(
    parameter logic RST_VAL = 1'b0
)
(
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic nv_load,
    input  wire logic nv_val,
    input  wire logic toggle,
    output var  logic q
);
    // reload from non-volatile storage on power-up, else toggle
    always_ff @(posedge MCLK)
    begin
        if (RST)
            q <= RST_VAL;
        else if (nv_load)
            q <= nv_val;
        else if (toggle)
            q <= ~q;
    end
endmodule : tfc_toggle_bit
`default_nettype wire

/* tfc_reader_model.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tfc_cfg.svh"
module tfc_reader_model
#(
    parameter int RTCAL_CYC = 1
)
(
    // clock
    input  wire logic        MCLK,
    // write and read requests
    output var  logic        WR_REQ,
    output var  logic        WR_BLOCK,
    output var  logic [15:0] WR_ADDR,
    output var  logic [15:0] WR_DATA,
    output var  logic        RD_REQ,
    output var  logic [15:0] RD_ADDR,
    // select and query
    output var  logic        SEL_REQ,
    output var  logic [15:0] SEL_PTR,
    output var  logic [7:0]  SEL_LEN,
    output var  logic        SEL_MASK,
    output var  logic        SEL_TRUNC,
    output var  logic        PWR_OK,
    output var  logic        QUERY_REQ
);
    initial
    begin
        {WR_REQ, WR_BLOCK, RD_REQ, SEL_REQ, QUERY_REQ} = 5'h00;
        {WR_ADDR, WR_DATA, RD_ADDR, SEL_PTR} = 64'h0;
        {SEL_LEN, SEL_MASK, SEL_TRUNC, PWR_OK} = 11'h000;
    end
    // released address, data, pointer and length lines show the inverse; WR_BLOCK, SEL_MASK, SEL_TRUNC and PWR_OK keep their value
    task automatic wr(input logic [15:0] a, input logic [15:0] d,
                      input logic b);
        @(negedge MCLK);
        {WR_ADDR, WR_DATA, WR_BLOCK, WR_REQ} = {a, d, b, 1'b1};
        @(negedge MCLK);
        {WR_ADDR, WR_DATA, WR_REQ} = {~a, ~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [15:0] a);
        @(negedge MCLK);
        {RD_ADDR, RD_REQ} = {a, 1'b1};
        @(negedge MCLK);
        {RD_ADDR, RD_REQ} = {~a, 1'b0};
    endtask : rd
    task automatic sel(input logic [15:0] p, input logic [7:0] l,
                       input logic m, input logic t, input logic pw);
        @(negedge MCLK);
        {SEL_PTR, SEL_LEN, SEL_MASK, SEL_TRUNC, PWR_OK} = {p, l, m, t, pw};
        SEL_REQ = 1'b1;
        @(negedge MCLK);
        {SEL_PTR, SEL_LEN, SEL_REQ} = {~p, ~l, 1'b0};
        // carrier only before the next command
        if (p == `TFC_ACT_PAR_ADDR || p == `TFC_ACT_PWR_ADDR)
            repeat (RTCAL_CYC + `TFC_GUARD_CYC) @(negedge MCLK);
    endtask : sel
    task automatic qry();
        @(negedge MCLK);
        // replies are never decoded, so collided ones pass
        QUERY_REQ = 1'b1;
        @(negedge MCLK);
        QUERY_REQ = 1'b0;
    endtask : qry
endmodule : tfc_reader_model
`default_nettype wire

/* rfid_tag_config_word_features_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tfc_cfg.svh"
module rfid_tag_config_word_features_bench
    import tfc_pkg::*;
;
    logic        MCLK, RST, NV_LOAD, SECURED;
    logic [15:0] NV_WORD, nvw;
    logic [47:0] sn;
    logic [1:0]  EPC_LOCK;
    wire logic   wr_req, wr_blk, rd_req, sel_req, sel_mask, sel_trunc;
    wire logic   pwr_ok, qry_req;
    wire logic [15:0] wr_addr, wr_data, rd_addr, sel_ptr;
    wire logic [7:0]  sel_len;
    logic        wr_done, wr_rej, rd_valid, tid_ind, max_bs, aaf;
    logic        par_act, pwr_act, par_open, par_wall;
    logic        sel_act, sel_match, nv_store;
    logic [15:0] rd_data, par_handle, nv_word_out;
    logic [1:0]  sel_q[$];
    logic [15:0] nv_q[$];
    logic [95:0] epc_init;
    logic [1:0]  wr_q[$];
    logic [15:0] rd_q[$];
    int          num_errors = 0;
    int          n_compared = 0;
    int          n_par = 0;
    int          seed = 20;
    tfc_features uut (.MCLK(MCLK), .RST(RST), .NV_LOAD(NV_LOAD),
        .NV_WORD(NV_WORD), .TAG_SERIAL_NUMBER(sn), .EPC_LOCK(EPC_LOCK),
        .SECURED(SECURED), .WR_REQ(wr_req), .WR_BLOCK(wr_blk),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req),
        .RD_ADDR(rd_addr), .SEL_REQ(sel_req), .SEL_PTR(sel_ptr),
        .SEL_LEN(sel_len), .SEL_MASK(sel_mask), .SEL_TRUNC(sel_trunc),
        .PWR_OK(pwr_ok), .QUERY_REQ(qry_req), .WR_DONE(wr_done),
        .WR_REJECT(wr_rej), .RD_VALID(rd_valid), .RD_DATA(rd_data),
        .TID_CFG_IND(tid_ind), .SEL_ACT(sel_act), .SEL_MATCH(sel_match),
        .MAX_BACKSCATTER(max_bs), .ARTICLE_ALARM_FLAG(aaf),
        .PAR_ACTIVE(par_act), .PWR_CHECK_ACTIVE(pwr_act),
        .PAR_OPEN(par_open), .PAR_HANDLE(par_handle),
        .PAR_WRITE_ALL(par_wall), .EPC_INIT(epc_init), .NV_STORE(nv_store),
        .NV_WORD_OUT(nv_word_out));
    tfc_reader_model m (.MCLK(MCLK), .WR_REQ(wr_req), .WR_BLOCK(wr_blk),
        .WR_ADDR(wr_addr), .WR_DATA(wr_data), .RD_REQ(rd_req),
        .RD_ADDR(rd_addr), .SEL_REQ(sel_req), .SEL_PTR(sel_ptr),
        .SEL_LEN(sel_len), .SEL_MASK(sel_mask), .SEL_TRUNC(sel_trunc),
        .PWR_OK(pwr_ok), .QUERY_REQ(qry_req));
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        MCLK = 1'b0;
        forever #25 MCLK = ~MCLK;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    task automatic cmp(input logic [95:0] got, input logic [95:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : cmp
    task automatic cmp_wr();
        cmp({wr_done, wr_rej}, wr_q.size() ? wr_q.pop_front() : 2'h3);
    endtask : cmp_wr
    task automatic cmp_rd();
        cmp(rd_data, rd_q.size() ? rd_q.pop_front() : 16'hDEAD);
    endtask : cmp_rd
    task automatic cmp_sel();
        cmp({sel_act, sel_match}, sel_q.size() ? sel_q.pop_front() : 2'h0);
    endtask : cmp_sel
    task automatic cmp_nv();
        cmp(nv_word_out, nv_q.size() ? nv_q.pop_front() : 16'hDEAD);
    endtask : cmp_nv
    function automatic int pending();
        return wr_q.size() + rd_q.size() + sel_q.size() + nv_q.size();
    endfunction : pending
    task automatic idle(input int n);
        repeat (n) @(negedge MCLK);
    endtask : idle
    task automatic do_reset();
        @(negedge MCLK);
        RST = 1'b1;
        idle(16);
        RST = 1'b0;
        idle(2);
    endtask : do_reset
    task automatic wrx(input logic [15:0] d, input logic b,
                       input logic [1:0] e);
        wr_q.push_back(e);
        m.wr(`TFC_CFG_WORD_ADDR, d, b);
        idle(3);
    endtask : wrx
    task automatic rdx(input logic [15:0] e);
        rd_q.push_back(e);
        m.rd(`TFC_CFG_WORD_ADDR);
        idle(3);
    endtask : rdx
    ////////////////////////////////////////////////////////////////////////
    // results come as pulses; each takes the oldest note
    always @(negedge MCLK)
    begin
        if (wr_done | wr_rej)
            cmp_wr();
        if (rd_valid)
            cmp_rd();
        if (sel_act | sel_match)
            cmp_sel();
        if (nv_store)
            cmp_nv();
        if (par_wall)
            n_par++;
    end
    initial
    begin
        repeat (100000) @(posedge MCLK);
        num_errors++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [1:0]  lk[4] = '{TFC_UNLOCKED, TFC_LOCKED, TFC_LOCKED,
                               TFC_PERMALOCK};
        logic [2:0]  lsb[4] = '{3'b001, 3'b000, 3'b010, 3'b010};
        logic [1:0]  lex[4] = '{2'h1, 2'h1, 2'h2, 2'h1};
        logic [15:0] sp[7] = '{16'h0202, 16'h0202, 16'h0202, 16'h0203,
                               16'h0204, 16'h0202, 16'h0204};
        logic [11:0] sf[7] = '{12'h01D, 12'h025, 12'h011, 12'h019,
                               12'h018, 12'h019, 12'h019};
        logic [1:0]  sx[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3};
        logic [1:0]  sm[7] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h2, 2'h3, 2'h3};
        RST = 1'b1;
        {NV_LOAD, SECURED, EPC_LOCK, NV_WORD} = 20'h0;
        sn = 48'({$random(seed), $random(seed)});
        nvw = 16'($random(seed));
        do_reset();
        cmp({max_bs, aaf, tid_ind}, 3'h5);
        cmp(epc_init, {48'h0, sn});
        rdx(16'h0200);
        nv_q.push_back(16'h8000);
        wrx(16'h8200, 1'b0, 2'h2);
        cmp({max_bs, aaf}, 2'h1);
        rdx(16'h8000);
        wrx(16'h0000, 1'b0, 2'h2);
        nv_q.push_back(16'h0200);
        wrx(16'hFFFF, 1'b0, 2'h2);
        rdx(16'h0200);
        for (int i = 0; i < 4; i++)
        begin
            {SECURED, EPC_LOCK} = {lsb[i][1], lk[i]};
            if (lex[i] == 2'h2)
                nv_q.push_back(16'h0000);
            wrx(16'h0200, lsb[i][0], lex[i]);
        end
        cmp(max_bs, 1'b0);
        // permalocked bank still lets actions fire
        for (int i = 0; i < 7; i++)
        begin
            if (sm[i] != 2'h0)
                sel_q.push_back(sm[i]);
            m.sel(sp[i], sf[i][11:4], sf[i][3],
                  sf[i][2], sf[i][0]);
            idle(3);
            cmp({par_act, pwr_act}, sx[i]);
        end
        cmp({max_bs, aaf}, 2'h0);
        rdx(16'h0014);
        m.qry();
        idle(3);
        cmp({par_open, par_handle}, {1'b1, `TFC_PAR_HANDLE});
        EPC_LOCK = TFC_UNLOCKED;
        wrx(16'h0000, 1'b0, 2'h2);
        cmp(n_par, 1);
        do_reset();
        cmp({par_act, pwr_act, par_open, max_bs}, 4'h1);
        NV_WORD = nvw;
        NV_LOAD = 1'b1;
        idle(1);
        NV_LOAD = 1'b0;
        idle(3);
        cmp({max_bs, aaf}, {nvw[9], nvw[15]});
        for (int i = 0; i < 20 && pending() > 0; i++)
            idle(1);
        if (pending() > 0)
            num_errors++;
        report_and_stop();
    end
endmodule : rfid_tag_config_word_features_bench
`default_nettype wire
